// >>> logic/root_event_defs.vh
// Purpose: Offsets, field positions, reset values for root event logic
// Assumes: Dword-aligned configuration addresses, 12-bit byte address
// Notes:   Included by root_port_pme_gpe_logic.v
`ifndef ROOT_EVENT_DEFS_VH
`define ROOT_EVENT_DEFS_VH

// Register offsets
`define ROOT_CONTROL_OFS            12'h0bc
`define ROOT_EVENT_STATUS_OFS       12'h0c0
`define LEGACY_MSG_CONTROL_OFS      12'h0ec

// root_event_status fields
`define WAKE_ID_MSB                 15
`define WAKE_ID_LSB                 0
`define WAKE_STATUS_BIT             16
`define WAKE_WAITING_BIT            17

// root_control fields
`define ROOT_CTRL_WIDTH             4
`define ROOT_INT_ENABLE_BIT         3

// legacy_event_message_control fields
`define GENERAL_FWD_ENABLE_BIT      0
`define HOTPLUG_MSG_ENABLE_BIT      1
`define WAKE_MSG_ENABLE_BIT         2

// Reset values
`define ROOT_CONTROL_RST            4'h0
`define WAKE_ID_RST                 16'h0000
`define LEGACY_CTRL_RST             3'h0

// Waiting-event queue
`define WAIT_DEPTH                  4
`define WAIT_PTR_W                  2
`define WAIT_CNT_W                  3
`define WAIT_FULL_CNT               3'h4

`endif

// >>> logic/root_port_pme_gpe_logic.v
// Purpose: Root-port wake event recording and legacy event messaging
// Assumes: Event inputs come from link logic on core_clk
// Notes:   Config port answers every access one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "root_event_defs.vh"

// Functional notes
// - A wake event arriving with no status recorded sets bit 16 and captures its sender identifier.
// - Bits 15:0 are read-only and hold the identifier of the latest delivered wake event sender.
// - Up to 4 further wake events wait while status is set; software clears it by writing 1 to bit 16 only.
// - Read-only bit 17 is set while at least one further wake event waits behind a set status.
// - Clearing the status with an event waiting delivers it at once, setting status and its identifier.
// - Bit 17 drops as soon as no wake event remains queued.
// - With bit 2 set every delivered wake event yields an assert then a deassert message to the hub.
// - With bit 1 set a hot-plug event with no assert outstanding yields an assert, then a deassert once slot status drops.
// - With bit 0 set general assert and deassert messages from the port are forwarded to the hub.
// - With bit 0 clear general assert and deassert messages from the port are dropped.
// - With root control bit 3 set, every setting of the wake status raises an interrupt.
// - Setting root control bit 3 while wake status is already set also raises an interrupt.
module root_port_pme_gpe_logic (
    // Clock and reset
    input  wire        core_clk,
    input  wire        arst_n,
    // Configuration access
    input  wire        cfg_req,
    input  wire        cfg_we,
    input  wire [11:0] cfg_addr,
    input  wire [3:0]  cfg_be,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    output reg         cfg_ack,
    // Events from the expansion port
    input  wire        wake_event_in,
    input  wire [15:0] wake_sender_in,
    input  wire        hotplug_event_in,
    input  wire        hotplug_status_in,
    input  wire        general_assert_in,
    input  wire        general_deassert_in,
    // Messages to the hub link
    output reg         wake_assert_msg,
    output reg         wake_deassert_msg,
    output reg         hotplug_assert_msg,
    output reg         hotplug_deassert_msg,
    output reg         general_assert_msg,
    output reg         general_deassert_msg,
    // Interrupt request pulse
    output reg         root_irq
);

    // Dword match on a byte address
    function addr_hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            addr_hit = (a[11:2] == ofs[11:2]);
        end
    endfunction

    reg [`ROOT_CTRL_WIDTH-1:0] root_control_q;
    reg [2:0]                  legacy_ctrl_q;
    reg                        wake_event_status_q;
    reg [15:0]                 wake_sender_identifier_q;
    reg [15:0]                 wait_mem [0:`WAIT_DEPTH-1];
    reg [`WAIT_PTR_W-1:0]      wait_rd_q;
    reg [`WAIT_PTR_W-1:0]      wait_wr_q;
    reg [`WAIT_CNT_W-1:0]      wait_cnt_q;
    reg                        wake_need_q;
    reg                        wake_sent_q;
    reg                        hotplug_sent_q;
    reg [`WAIT_PTR_W-1:0]      wait_rd_d;
    reg [`WAIT_PTR_W-1:0]      wait_wr_d;
    reg [`WAIT_CNT_W-1:0]      wait_cnt_d;
    reg                        wake_event_status_d;
    reg [15:0]                 wake_sender_identifier_d;
    reg                        root_irq_d;
    reg                        wake_need_d;
    reg                        wake_sent_d;

    wire wr_status  = cfg_req & cfg_we & cfg_be[2] &
                      addr_hit(cfg_addr, `ROOT_EVENT_STATUS_OFS);
    wire wr_root_control    = cfg_req & cfg_we & cfg_be[0] &
                      addr_hit(cfg_addr, `ROOT_CONTROL_OFS);
    wire wr_legacy  = cfg_req & cfg_we & cfg_be[0] &
                      addr_hit(cfg_addr, `LEGACY_MSG_CONTROL_OFS);

    wire wake_message_enable          = legacy_ctrl_q[`WAKE_MSG_ENABLE_BIT];
    wire hotplug_message_enable       = legacy_ctrl_q[`HOTPLUG_MSG_ENABLE_BIT];
    wire general_event_forward_enable =
        legacy_ctrl_q[`GENERAL_FWD_ENABLE_BIT];
    wire root_int_enable = root_control_q[`ROOT_INT_ENABLE_BIT];

    wire status_clr   = wr_status & cfg_wdata[`WAKE_STATUS_BIT];
    wire status_held  = wake_event_status_q & ~status_clr;
    wire wait_nonzero = (wait_cnt_q != {`WAIT_CNT_W{1'b0}});
    wire wait_full    = (wait_cnt_q == `WAIT_FULL_CNT);

    // waiting event wins over a new arrival
    wire deliver_wait = ~status_held & wait_nonzero;
    // direct delivery when nothing is recorded
    wire deliver_new  = ~status_held & ~wait_nonzero & wake_event_in;
    wire deliver      = deliver_wait | deliver_new;
    // new event queued while status stays set
    // A fifth event while full is dropped, unless a slot frees now
    wire push         = wake_event_in & ~deliver_new &
                        (~wait_full | deliver_wait);
    wire pop          = deliver_wait;

    wire wake_event_waiting = wake_event_status_q & wait_nonzero;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            root_control_q <= `ROOT_CONTROL_RST;
            legacy_ctrl_q  <= `LEGACY_CTRL_RST;
        end else begin
            if (wr_root_control)
                root_control_q <= cfg_wdata[`ROOT_CTRL_WIDTH-1:0];
            if (wr_legacy)
                legacy_ctrl_q <= cfg_wdata[2:0];
        end
    end

    // Waiting-event storage
    always @(posedge core_clk) begin
        if (push)
            wait_mem[wait_wr_q] <= wake_sender_in;
    end

    // Queue pointers and fill count, next values
    always @* begin
        wait_rd_d  = wait_rd_q;
        wait_wr_d  = wait_wr_q;
        wait_cnt_d = wait_cnt_q;
        if (push)
            wait_wr_d = wait_wr_q + 1'b1;
        if (pop)
            wait_rd_d = wait_rd_q + 1'b1;
        if (push & ~pop)
            wait_cnt_d = wait_cnt_q + 1'b1;
        else if (pop & ~push)
            wait_cnt_d = wait_cnt_q - 1'b1;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_rd_q  <= {`WAIT_PTR_W{1'b0}};
            wait_wr_q  <= {`WAIT_PTR_W{1'b0}};
            wait_cnt_q <= {`WAIT_CNT_W{1'b0}};
        end else begin
            wait_rd_q  <= wait_rd_d;
            wait_wr_q  <= wait_wr_d;
            wait_cnt_q <= wait_cnt_d;
        end
    end

    // Status and identifier, next values
    always @* begin
        // set wins over a same-cycle clear
        wake_event_status_d      = status_held | deliver;
        wake_sender_identifier_d = wake_sender_identifier_q;
        if (deliver_wait)
            wake_sender_identifier_d = wait_mem[wait_rd_q];
        else if (deliver_new)
            wake_sender_identifier_d = wake_sender_in;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_event_status_q      <= 1'b0;
            wake_sender_identifier_q <= `WAKE_ID_RST;
        end else begin
            wake_event_status_q      <= wake_event_status_d;
            wake_sender_identifier_q <= wake_sender_identifier_d;
        end
    end

    // Interrupt pulse
    wire root_control_rise = wr_root_control & cfg_wdata[`ROOT_INT_ENABLE_BIT] &
                     ~root_int_enable;

    always @* begin
        root_irq_d = deliver & root_int_enable;
        // enable rising over a status set now or before
        if (root_control_rise & wake_event_status_d)
            root_irq_d = 1'b1;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            root_irq <= 1'b0;
        end else begin
            root_irq <= root_irq_d;
        end
    end

    // Wake messages: assert once per delivery, deassert after clear
    wire send_wake_assert   = wake_need_q & ~wake_sent_q;
    wire send_wake_deassert = wake_sent_q &
                              (status_clr | ~wake_event_status_q);

    // Deassert still goes out if the enable drops after its assert
    always @* begin
        wake_need_d = wake_need_q;
        wake_sent_d = wake_sent_q;
        if (deliver & wake_message_enable)
            wake_need_d = 1'b1;
        else if (send_wake_assert)
            wake_need_d = 1'b0;
        // deassert pairs with a sent assert
        if (send_wake_assert)
            wake_sent_d = 1'b1;
        else if (send_wake_deassert)
            wake_sent_d = 1'b0;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wake_need_q       <= 1'b0;
            wake_sent_q       <= 1'b0;
            wake_assert_msg   <= 1'b0;
            wake_deassert_msg <= 1'b0;
        end else begin
            wake_need_q       <= wake_need_d;
            wake_sent_q       <= wake_sent_d;
            wake_assert_msg   <= send_wake_assert;
            wake_deassert_msg <= send_wake_deassert;
        end
    end

    // Hot-plug assert on an event, deassert once the slot status level drops
    wire send_hp_assert   = hotplug_event_in & hotplug_message_enable &
                            ~hotplug_sent_q;
    wire send_hp_deassert = hotplug_sent_q & ~hotplug_status_in;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hotplug_sent_q       <= 1'b0;
            hotplug_assert_msg   <= 1'b0;
            hotplug_deassert_msg <= 1'b0;
        end else begin
            if (send_hp_assert)
                hotplug_sent_q <= 1'b1;
            else if (send_hp_deassert)
                hotplug_sent_q <= 1'b0;
            hotplug_assert_msg   <= send_hp_assert;
            hotplug_deassert_msg <= send_hp_deassert;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            general_assert_msg   <= 1'b0;
            general_deassert_msg <= 1'b0;
        end else begin
            general_assert_msg   <= general_assert_in &
                                    general_event_forward_enable;
            general_deassert_msg <= general_deassert_in &
                                    general_event_forward_enable;
        end
    end

    // Read path
    // Reserved bits and unmapped offsets read as zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (addr_hit(cfg_addr, `ROOT_CONTROL_OFS))
            rd_mux[`ROOT_CTRL_WIDTH-1:0] = root_control_q;
        else if (addr_hit(cfg_addr, `ROOT_EVENT_STATUS_OFS)) begin
            rd_mux[`WAKE_ID_MSB:`WAKE_ID_LSB] = wake_sender_identifier_q;
            rd_mux[`WAKE_STATUS_BIT]          = wake_event_status_q;
            rd_mux[`WAKE_WAITING_BIT]         = wake_event_waiting;
        end else if (addr_hit(cfg_addr, `LEGACY_MSG_CONTROL_OFS))
            rd_mux[2:0] = legacy_ctrl_q;
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack   <= 1'b0;
        end else begin
            cfg_ack <= cfg_req;
            if (cfg_req & ~cfg_we)
                cfg_rdata <= rd_mux;
            else
                cfg_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// >>> verification/root_event_chk.sv
// Purpose: Port checks for root event logic
// Assumes: Config writes act at the edge that takes them
// Notes:   Enables shadowed from config writes
`timescale 1ns/1ps
`default_nettype none
module root_event_chk (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        arst_n,
    // Config port
    input wire logic        cfg_req,
    input wire logic        cfg_we,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    // Events from the port
    input wire logic        wake_event_in,
    input wire logic        hotplug_event_in,
    input wire logic        hotplug_status_in,
    input wire logic        general_assert_in,
    input wire logic        general_deassert_in,
    // Messages and interrupt
    input wire logic        root_irq,
    input wire logic        wake_assert_msg,
    input wire logic        wake_deassert_msg,
    input wire logic        hotplug_assert_msg,
    input wire logic        hotplug_deassert_msg,
    input wire logic        general_assert_msg,
    input wire logic        general_deassert_msg
);
    logic [2:0] en_q;
    logic       irq_en_q, wake_out_q;
    wire        wr = cfg_req & cfg_we;
    wire        clr = wr & cfg_be[2] & cfg_wdata[16] & cfg_addr == 12'h0c0;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Shadow enables and open wake message
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {en_q, irq_en_q, wake_out_q} <= 5'h00;
        end else begin
            if (wr && cfg_be[0] && cfg_addr == 12'h0ec)
                en_q <= cfg_wdata[2:0];
            if (wr && cfg_be[0] && cfg_addr == 12'h0bc)
                irq_en_q <= cfg_wdata[3];
            if (wake_assert_msg | wake_deassert_msg)
                wake_out_q <= wake_assert_msg;
        end
    end
    irq_gate_a: assert property (root_irq |-> $past(irq_en_q) || irq_en_q)
        else $error("irq while disabled");
    irq_cause_a: assert property (
        root_irq |-> $past(wake_event_in | wr)) else $error("irq no cause");
    clr_deassert_a: assert property (
        wake_deassert_msg |-> $past(clr)) else $error("deassert no clear");
    wake_pair_a: assert property (
        wake_deassert_msg |-> wake_out_q) else $error("deassert no assert");
    wake_gate_a: assert property (
        wake_assert_msg |-> $past(en_q[2], 2)) else $error("wake disabled");
    hp_gate_a: assert property (
        hotplug_assert_msg |-> $past(hotplug_event_in & en_q[1]))
        else $error("hot-plug assert no event");
    hp_clear_a: assert property (
        hotplug_deassert_msg |-> !$past(hotplug_status_in))
        else $error("hot-plug deassert early");
    gen_fwd_a: assert property (
        general_assert_msg == $past(general_assert_in & en_q[0]))
        else $error("general assert forward");
    gen_drop_a: assert property (
        general_deassert_msg == $past(general_deassert_in & en_q[0]))
        else $error("general deassert forward");
    cover property (root_irq && wake_deassert_msg);
    cover property (hotplug_deassert_msg);
    cover property (general_deassert_msg);
endmodule
bind root_port_pme_gpe_logic root_event_chk i_root_event_chk (.*);
`default_nettype wire

// >>> verification/hub_msg_model.sv
// Purpose: Hub side receiver of legacy event messages
// Assumes: Messages are one-cycle pulses on core_clk
// Notes:   Index 6 counts interrupt pulses
`timescale 1ns/1ps
`default_nettype none
module hub_msg_model (
    // Clock and reset
    input  wire logic            core_clk,
    input  wire logic            arst_n,
    // Message pulses, interrupt in bit 6
    input  wire logic [6:0]      msg,
    // Pulses received per kind
    output var  logic [6:0][7:0] cnt
);
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 56'h0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (msg[i])
                    cnt[i] <= cnt[i] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/root_port_pme_gpe_logic_tb_top.sv
// Purpose: Register and event sequences for root event logic
// Assumes: Inputs change on the falling edge
// Notes:   Hub model counts messages and interrupts
`timescale 1ns/1ps
`default_nettype none
module root_port_pme_gpe_logic_tb_top;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        cfg_req = 1'b0;
    logic        cfg_we = 1'b0;
    logic [3:0]  cfg_be = 4'hf;
    logic        cfg_ack, root_irq;
    logic [11:0] cfg_addr = 12'h000;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rdata_s;
    logic [15:0] wake_sender_in = 16'h0000;
    logic [4:0]  ev = 5'h00;
    wire  [5:0]  msg;
    wire  [6:0][7:0] cnt;
    int          error_cnt, comparisons, cycles;

    root_port_pme_gpe_logic i_root_port_pme_gpe_logic (.*,
        .wake_event_in(ev[0]), .hotplug_event_in(ev[1]),
        .hotplug_status_in(ev[2]), .general_assert_in(ev[3]),
        .general_deassert_in(ev[4]), .wake_assert_msg(msg[0]),
        .wake_deassert_msg(msg[1]), .hotplug_assert_msg(msg[2]),
        .hotplug_deassert_msg(msg[3]), .general_assert_msg(msg[4]),
        .general_deassert_msg(msg[5]));
    hub_msg_model i_hub_msg_model (.core_clk(core_clk), .arst_n(arst_n),
        .msg({root_irq, msg}), .cnt(cnt));

    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic check(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic counts(input logic [6:0][7:0] e);
        for (int i = 0; i < 7; i++)
            check({24'h0, cnt[i]}, {24'h0, e[i]});
    endtask
    task automatic cfg(input logic we, input logic [11:0] a,
                       input logic [31:0] d);
        cfg_req = 1'b1;
        cfg_we = we;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge core_clk);
        cfg_req = 1'b0;
        rdata_s = cfg_rdata;
        check({31'h0, cfg_ack}, 32'h1);
        @(negedge core_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        cfg(1'b0, a, 32'h0);
        check(rdata_s, exp);
    endtask
    task automatic pulse(input logic [4:0] on, off, input logic [15:0] id);
        ev = on;
        wake_sender_in = id;
        @(negedge core_clk);
        ev = off;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic report_and_stop();
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge core_clk);
        arst_n = 1'b1;
        rd(12'h0c0, 32'h0);
        rd(12'h0ec, 32'h0);
        cfg(1'b1, 12'h0ec, 32'hffffffff);
        rd(12'h0ec, 32'h7);
        rd(12'h100, 32'h0);
        pulse(5'h01, 5'h00, 16'h1234);
        rd(12'h0c0, 32'h00011234);
        cfg(1'b1, 12'h0bc, 32'h8);
        counts(56'h01_00_00_00_00_00_01);
        pulse(5'h01, 5'h00, 16'h0a0b);
        pulse(5'h01, 5'h00, 16'h0c0d);
        cfg(1'b1, 12'h0c0, 32'h0000ffff);
        cfg_be = 4'hb;
        cfg(1'b1, 12'h0c0, 32'h00010000);
        cfg_be = 4'hf;
        rd(12'h0c0, 32'h00031234);
        cfg(1'b1, 12'h0c0, 32'h00010000);
        rd(12'h0c0, 32'h00030a0b);
        counts(56'h02_00_00_00_00_01_02);
        cfg(1'b1, 12'h0c0, 32'h00010000);
        rd(12'h0c0, 32'h00010c0d);
        cfg(1'b1, 12'h0c0, 32'h00010000);
        counts(56'h03_00_00_00_00_03_03);
        cfg(1'b1, 12'h0ec, 32'h0);
        pulse(5'h01, 5'h00, 16'h5555);
        pulse(5'h06, 5'h04, 16'h0000);
        pulse(5'h08, 5'h00, 16'h0000);
        pulse(5'h10, 5'h00, 16'h0000);
        rd(12'h0c0, 32'h00015555);
        counts(56'h04_00_00_00_00_03_03);
        cfg(1'b1, 12'h0c0, 32'h00010000);
        cfg(1'b1, 12'h0ec, 32'h7);
        pulse(5'h06, 5'h04, 16'h0000);
        pulse(5'h08, 5'h00, 16'h0000);
        pulse(5'h10, 5'h00, 16'h0000);
        counts(56'h04_01_01_01_01_03_03);
        report_and_stop();
    end
endmodule
`default_nettype wire
